// ==== dpbt_map.vh ====
/*
  constants for the ddr pseudo-static memory device model:
  command/address field positions, array size, latency and refresh timing.
  assumes a 40 MHz core_clk sampling a slower host bus clock.
*/
`ifndef DPBT_MAP_VH
`define DPBT_MAP_VH

// core clock period
`define CLK_PERIOD_NS   25

// command/address word fields (48-bit word, first byte in bits 47:40)
`define CA_RW_BIT       47
`define CA_SPACE_BIT    46
`define CA_LINEAR_BIT   45
`define CA_ROW_LSB      16
`define CA_COL_LSB      0
`define ROW_W           5
`define COL_W           3
`define CA_LAST_EDGE    3'h5

// word array
`define ADDR_W          8
`define MEM_WORDS       256
`define ADDR_ONE        8'h01

// wrapped burst group: 16 words, aligned
`define WRAP_BITS       4
`define WRAP_ONE        4'h1

// initial access latency in bus clock cycles, doubled when refresh is due
`define LAT_CYC         5'h06
`define LAT_LONG_CYC    5'h0c

// refresh spacing (longest time, rounds down) and duration (least, rounds up)
`define REF_GAP_NS      50000
`define REF_GAP_CYC     (`REF_GAP_NS / `CLK_PERIOD_NS)
`define REF_BUSY_NS     500
`define REF_BUSY_CYC    ((`REF_BUSY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// pin vector layout and idle value (reset pin high, select high)
`define PIN_W           13
`define PIN_RST         12
`define PIN_CS          11
`define PIN_CK          10
`define PIN_CKN         9
`define PIN_READ_WRITE_STROBE        8
`define PIN_IDLE        13'h1a00

`endif

// ==== dpbt_device.v ====
/*
  device side of a self-refreshing pseudo-static memory on an 8-bit
  double-data-rate bus: command/address capture, refresh latency signalling,
  wrapped and linear bursts, read strobe and masked writes, hidden refresh.
  assumes every bus pin is asynchronous to core_clk and changes slowly
  enough (bus clock period of at least 8 core cycles) to be oversampled.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dpbt_map.vh"

// Notes on behaviour
// - refresh runs internally, never starts during data transfer
// - one word per clock, two bytes
// - command, address, data share eight lines
// - capture on host bus clock edges
// - strobe high in command phase if refresh
// - strobe level sets initial latency length
// - read strobe toggles edge aligned with data
// - write byte stored only with strobe low
// - word advances each clock, type per command
// - wrapped burst returns within aligned group
// - linear burst continues until select rises
// - addresses count 16-bit words only
// - row, type first; column third cycle
// - linear burst crosses rows without stalling
// - reset pin low releases lines, reinitialises
module dpbt_device (
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire       hwResetN,
  input  wire       chipSelN,
  input  wire       busClk,
  input  wire       complementClock,
  input  wire [7:0] dqIn,
  output reg  [7:0] dqOut,
  output reg        dqOe,
  input  wire       rwdsIn,
  output reg        rwdsOut,
  output reg        rwdsOe
);

  // one-hot transaction states
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_CA   = 5'b00010;
  localparam [4:0] ST_LAT  = 5'b00100;
  localparam [4:0] ST_RD   = 5'b01000;
  localparam [4:0] ST_WR   = 5'b10000;

  // refresh counts are worked out at full width, then cut to the counters
  localparam [31:0] REF_GAP_FULL  = `REF_GAP_CYC;
  localparam [31:0] REF_BUSY_FULL = `REF_BUSY_CYC;
  localparam [11:0] REF_GAP       = REF_GAP_FULL[11:0];
  localparam [5:0]  REF_BUSY      = REF_BUSY_FULL[5:0];

  wire [`PIN_W-1:0] pinVec;
  wire [`PIN_W-1:0] pinStable;
  reg  [`PIN_W-1:0] sync1_reg;
  reg  [`PIN_W-1:0] sync2_reg;
  reg  [`PIN_W-1:0] sync3_reg;
  reg  [`PIN_W-1:0] filt_reg;

  reg  [4:0]        state_reg;
  reg               ckPrev_reg;
  reg  [2:0]        caCnt_reg;
  reg  [39:0]       caShift_reg;
  reg               isRead_reg;
  reg               linear_reg;
  reg               regSpace_reg;
  reg               longLat_reg;
  reg  [4:0]        latCnt_reg;
  reg  [`ADDR_W-1:0] addr_reg;
  reg  [7:0]        loByte_reg;
  reg  [7:0]        hiByte_reg;
  reg               hiMask_reg;
  reg               wrHalf_reg; // rise byte of a write word held

  reg               refPending_reg;
  reg  [11:0]       refTimer_reg;
  reg  [5:0]        refBusy_reg;

  reg  [15:0]       mem [0:`MEM_WORDS-1];

  assign pinVec = {hwResetN, chipSelN, busClk, complementClock, rwdsIn, dqIn};

  // per pin: a change counts once the second and third stages agree
  genvar g;
  generate
    for (g = 0; g < `PIN_W; g = g + 1)
    begin : gAgree
      assign pinStable[g] = (sync2_reg[g] == sync3_reg[g]);
    end
  endgenerate

  // three-stage synchroniser and agreement filter for all bus pins
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sync1_reg <= `PIN_IDLE;
      sync2_reg <= `PIN_IDLE;
      sync3_reg <= `PIN_IDLE;
      filt_reg  <= `PIN_IDLE;
    end
    else
    begin
      sync1_reg <= pinVec;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= (filt_reg & ~pinStable) | (sync3_reg & pinStable);
    end
  end

  // filtered pin views
  wire       pinRstN = filt_reg[`PIN_RST];
  wire       csN     = filt_reg[`PIN_CS];
  wire       ckHigh  = filt_reg[`PIN_CK] & ~filt_reg[`PIN_CKN];
  wire       rwdsS   = filt_reg[`PIN_READ_WRITE_STROBE];
  wire [7:0] dqS     = filt_reg[7:0];

  // bus clock edges, found by the core clock
  wire ckRise = ckHigh & ~ckPrev_reg;
  wire ckFall = ~ckHigh & ckPrev_reg;
  wire ckEdge = ckRise | ckFall;

  // command/address decode from the five stored bytes plus the sixth
  wire [47:0] caWord = {caShift_reg, dqS};
  wire [`ADDR_W-1:0] caAddr = {caWord[`CA_ROW_LSB +: `ROW_W], caWord[`CA_COL_LSB +: `COL_W]};

  // refresh state seen by a new transaction
  wire needRef = refPending_reg | (refBusy_reg != 6'h00);
  wire inData  = (state_reg == ST_RD) || (state_reg == ST_WR);
  wire refStart = refPending_reg && (refBusy_reg == 6'h00) && !inData;
  wire refDue   = (refTimer_reg == REF_GAP - 12'h001);

  wire [4:0] latTarget = longLat_reg ? `LAT_LONG_CYC : `LAT_CYC;

  // next word: wrap inside the aligned group, or run on linearly
  wire [`ADDR_W-1:0] addrNext = linear_reg ? (addr_reg + `ADDR_ONE)
    : {addr_reg[`ADDR_W-1:`WRAP_BITS], addr_reg[`WRAP_BITS-1:0] + `WRAP_ONE};

  // write strobes: each byte lands only when its mask was low
  // the fall after the latency-ending rise carries no byte, so a word
  // is only stored once its rise byte has been taken
  wire wrPhase = (state_reg == ST_WR) && ckFall && wrHalf_reg && !regSpace_reg;
  wire wrHi    = wrPhase && !hiMask_reg;
  wire wrLo    = wrPhase && !rwdsS;

  // word array write port; the word is completed on the falling edge
  always @(posedge core_clk)
  begin
    if (wrHi)
      mem[addr_reg][15:8] <= hiByte_reg;
    if (wrLo)
      mem[addr_reg][7:0] <= dqS;
  end

  // hidden refresh: timer, pending flag, busy period
  always @(posedge core_clk)
  begin
    if (!rst_n || !pinRstN)
    begin
      refTimer_reg   <= 12'h000;
      refPending_reg <= 1'b0;
      refBusy_reg    <= 6'h00;
    end
    else
    begin
      refTimer_reg <= refDue ? 12'h000 : refTimer_reg + 12'h001;
      // a new request wins over the clear of the old one
      refPending_reg <= refDue | (refPending_reg & ~refStart);
      if (refStart)
        refBusy_reg <= REF_BUSY;
      else if (refBusy_reg != 6'h00)
        refBusy_reg <= refBusy_reg - 6'h01;
    end
  end

  // transaction state machine and pin drivers
  always @(posedge core_clk)
  begin
    if (!rst_n || !pinRstN)
    begin
      state_reg    <= ST_IDLE;
      ckPrev_reg   <= 1'b0;
      caCnt_reg    <= 3'h0;
      caShift_reg  <= 40'h0000000000;
      isRead_reg   <= 1'b0;
      linear_reg   <= 1'b0;
      regSpace_reg <= 1'b0;
      longLat_reg  <= 1'b0;
      latCnt_reg   <= 5'h00;
      addr_reg     <= 8'h00;
      loByte_reg   <= 8'h00;
      hiByte_reg   <= 8'h00;
      hiMask_reg   <= 1'b1;
      wrHalf_reg   <= 1'b0;
      dqOut        <= 8'h00;
      dqOe         <= 1'b0;
      rwdsOut      <= 1'b0;
      rwdsOe       <= 1'b0;
    end
    else if (csN)
    begin
      // deselected: release the lines and wait for the next select
      state_reg  <= ST_IDLE;
      ckPrev_reg <= ckHigh;
      dqOe       <= 1'b0;
      rwdsOe     <= 1'b0;
      rwdsOut    <= 1'b0;
      wrHalf_reg <= 1'b0;
    end
    else
    begin
      ckPrev_reg <= ckHigh;
      case (state_reg)
        ST_IDLE:
        begin
          // select seen with clock idle: report refresh state at once
          state_reg   <= ST_CA;
          caCnt_reg   <= 3'h0;
          longLat_reg <= needRef;
          rwdsOe      <= 1'b1;
          rwdsOut     <= needRef;
        end
        ST_CA:
        begin
          if (ckEdge)
          begin
            caShift_reg <= {caShift_reg[31:0], dqS};
            caCnt_reg   <= caCnt_reg + 3'h1;
            if (caCnt_reg == `CA_LAST_EDGE)
            begin
              // sixth byte: decode and start counting latency
              state_reg    <= ST_LAT;
              latCnt_reg   <= 5'h00;
              isRead_reg   <= caWord[`CA_RW_BIT];
              regSpace_reg <= caWord[`CA_SPACE_BIT];
              linear_reg   <= caWord[`CA_LINEAR_BIT];
              addr_reg     <= caAddr;
              rwdsOut      <= 1'b0;
              rwdsOe       <= caWord[`CA_RW_BIT]; // write: host owns the mask
            end
          end
        end
        ST_LAT:
        begin
          if (ckRise)
          begin
            latCnt_reg <= latCnt_reg + 5'h01;
            if (latCnt_reg == latTarget - 5'h01)
            begin
              // this rise ends the latency; data starts on the next rise
              state_reg  <= isRead_reg ? ST_RD : ST_WR;
              wrHalf_reg <= 1'b0;
            end
          end
        end
        ST_RD:
        begin
          if (ckRise)
          begin
            // first byte of the word with the strobe rising
            dqOut      <= regSpace_reg ? 8'h00 : mem[addr_reg][15:8];
            loByte_reg <= regSpace_reg ? 8'h00 : mem[addr_reg][7:0];
            dqOe       <= 1'b1;
            rwdsOut    <= 1'b1;
          end
          else if (ckFall && dqOe)
          begin
            // second byte with the strobe falling, then step the burst;
            // the fall ending the latency finds dqOe low and is skipped
            dqOut    <= loByte_reg;
            rwdsOut  <= 1'b0;
            addr_reg <= addrNext;
          end
        end
        ST_WR:
        begin
          if (ckRise)
          begin
            // rise byte and its mask wait for the fall byte
            hiByte_reg <= dqS;
            hiMask_reg <= rwdsS;
            wrHalf_reg <= 1'b1;
          end
          else if (ckFall && wrHalf_reg)
          begin
            // word complete: step the burst, wait for the next rise
            addr_reg   <= addrNext;
            wrHalf_reg <= 1'b0;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
          dqOe      <= 1'b0;
          rwdsOe    <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== dpbt_chk_asserts.sv ====
/* pin checks on the memory device.
   assumes the bench bus half period of four core cycles. */
`timescale 1ns/1ps
`default_nettype none
module dpbt_chk (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       hwResetN,
  input wire logic       chipSelN,
  input wire logic       busClk,
  input wire logic       complementClock,
  input wire logic [7:0] dqIn,
  input wire logic [7:0] dqOut,
  input wire logic       dqOe,
  input wire logic       rwdsIn,
  input wire logic       rwdsOut,
  input wire logic       rwdsOe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // lines released when idle or in reset
  desel_free_a: assert property (chipSelN [*8] |-> !dqOe && !rwdsOe)
    else $error("driven when idle");
  rst_free_a: assert property (!hwResetN [*8] |-> !dqOe && !rwdsOe)
    else $error("driven in reset");
  // command phase
  ca_free_a: assert property ($fell(chipSelN) |-> !dqOe [*8])
    else $error("dq driven early");
  rfsh_flag_a: assert property ($fell(chipSelN) && hwResetN |-> ##[1:8] rwdsOe [*8])
    else $error("no latency flag");
  // read strobe framing
  pre_amble_a: assert property ($rose(dqOe) |-> rwdsOut && $past(rwdsOe) && !$past(rwdsOut))
    else $error("no preamble");
  edge_align_a: assert property (dqOe && $past(dqOe) && $changed(dqOut) |-> $changed(rwdsOut))
    else $error("data without edge");
  strobe_on_a: assert property (dqOe |-> rwdsOe)
    else $error("no strobe");
  ddr_rate_a: assert property (dqOe && $changed(rwdsOut) |=> (!dqOe || $stable(rwdsOut)) [*3])
    else $error("strobe too fast");
  // main scenarios
  cover property ($rose(dqOe));
  cover property ($fell(chipSelN) ##[1:8] rwdsOut && rwdsOe);
  cover property (!hwResetN);
endmodule
`default_nettype wire

// ==== dpbt_host.sv ====
/* host bus model: select, bus clock, command bytes, masked writes.
   assumes a 40 MHz core_clk; read bytes taken on strobe changes. */
`timescale 1ns/1ps
`default_nettype none
module dpbt_host (
  input  wire logic       core_clk,
  input  wire logic [7:0] devDq,
  input  wire logic       devDqOe,
  input  wire logic       devRwds,
  input  wire logic       devRwdsOe,
  output var  logic       chipSelN,
  output var  logic       busClk,
  output wire logic [7:0] dqIn,
  output wire logic       rwdsIn
);
  logic [7:0]  hDq, flt;
  logic        hOe, hRw, hRwOe, prv, rf;
  logic [15:0] wd [0:255];
  logic [1:0]  wm [0:255];
  logic [7:0]  rq [$];
  // resolved lines; a released line shows a moving pattern
  assign dqIn = devDqOe ? devDq : hOe ? hDq : flt;
  assign rwdsIn = devRwdsOe ? devRwds : hRwOe ? hRw : flt[0];
  initial
  begin
    {chipSelN, busClk, hOe, hRwOe, flt} = {4'b1000, 8'h00};
  end
  // read bytes on each strobe change
  always @(posedge core_clk)
  begin
    flt <= flt + 8'h3b;
    prv <= devRwds;
    if (devDqOe && devRwdsOe && devRwds != prv)
      rq.push_back(devDq);
  end
  // one half period: data first, clock edge centred in the half
  task automatic half(input logic [7:0] d, input logic o, input logic m, input logic mo);
  begin
    hDq <= d;
    hOe <= o;
    hRw <= m;
    hRwOe <= mo;
    repeat (2) @(posedge core_clk);
    busClk <= ~busClk;
    repeat (2) @(posedge core_clk);
  end
  endtask
  // select, six command bytes, latency, data, deselect
  task automatic run(input logic [47:0] ca, input integer n);
    integer i;
  begin
    rq.delete();
    chipSelN <= 1'b0;
    repeat (8) @(posedge core_clk);
    rf = rwdsIn;
    for (i = 0; i < 6; i++)
      half(ca[47-8*i -: 8], 1'b1, 1'b0, 1'b0);
    for (i = 0; i < (rf ? 24 : 12); i++)
      half(8'h00, 1'b0, 1'b0, 1'b0);
    for (i = 0; i < 2 * n; i++)
      half(wd[i/2][(i[0] ? 7 : 15) -: 8], ~ca[47], wm[i/2][~i[0]], ~ca[47]);
    repeat (8) @(posedge core_clk);
    {chipSelN, hOe, hRwOe} <= 3'b100;
    repeat (12) @(posedge core_clk);
  end
  endtask
endmodule
`default_nettype wire

// ==== dpbt_tb.sv ====
/* bench for the memory device: table of bursts, then register
   space and reset pin cases. assumes the host model beside it. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin nFail++; $display("[ERR] %0t %h %h", $time, g, e); end end
module tb;
  logic        core_clk, rst_n, hwResetN, w, lin, rf;
  logic [7:0]  a, s;
  logic [8:0]  n;
  logic [15:0] mem [0:255];
  logic [15:0] ex [0:255];
  logic [19:0] rows [0:4];
  wire  [7:0]  dqOut, dqIn;
  wire         dqOe, rwdsOut, rwdsOe, chipSelN, busClk, rwdsIn;
  integer      nFail, nTests, r, k;
  dpbt_device u_dut (.core_clk(core_clk), .rst_n(rst_n), .hwResetN(hwResetN), .chipSelN(chipSelN),
    .busClk(busClk), .complementClock(~busClk), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
    .rwdsIn(rwdsIn), .rwdsOut(rwdsOut), .rwdsOe(rwdsOe));
  dpbt_host u_host (.core_clk(core_clk), .devDq(dqOut), .devDqOe(dqOe), .devRwds(rwdsOut),
    .devRwdsOe(rwdsOe), .chipSelN(chipSelN), .busClk(busClk), .dqIn(dqIn), .rwdsIn(rwdsIn));
  // verdict and end of run
  task testDone;
  begin
    $display("checks %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  // core clock
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge core_clk);
    nFail++;
    testDone;
  end
  // rows: write, linear, start word, words, latency flag
  initial
  begin
    rows = '{{2'b11, 8'h00, 9'h100, 1'b0}, {2'b01, 8'h06, 9'h004, 1'b1}, {2'b00, 8'h1d, 9'h010, 1'b0},
             {2'b10, 8'h2e, 9'h003, 1'b0}, {2'b00, 8'h2e, 9'h003, 1'b0}};
    {nFail, nTests} = 64'h0;
    {rst_n, hwResetN} = 2'b01;
    repeat (6) @(posedge core_clk);
    `CHK({dqOe, rwdsOe, rwdsOut, dqOut}, 11'h000)
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    for (r = 0; r < 5; r++)
    begin
      {w, lin, s, n, rf} = rows[r];
      a = s;
      for (k = 0; k < n; k++)
      begin
        u_host.wd[k] = lin ? {a, ~a} : {~a, a};
        u_host.wm[k] = lin ? 2'b00 : 2'b01 << k;
        ex[k] = mem[a];
        if (w && !u_host.wm[k][1]) mem[a][15:8] = u_host.wd[k][15:8];
        if (w && !u_host.wm[k][0]) mem[a][7:0] = u_host.wd[k][7:0];
        a = lin ? a + 8'h01 : {a[7:4], a[3:0] + 4'h1};
      end
      u_host.run({~w, 1'b0, lin, 24'h0, s[7:3], 13'h0, s[2:0]}, n);
      `CHK(u_host.rf, rf)
      `CHK(u_host.rq.size(), w ? 0 : 2 * n)
      for (k = 0; k < n && !w; k++)
        `CHK({u_host.rq[2*k], u_host.rq[2*k+1]}, ex[k])
    end
    // register space reads as zero
    u_host.run({2'b11, 46'h0}, 2);
    `CHK(u_host.rq.size(), 4)
    `CHK({u_host.rq[0], u_host.rq[1], u_host.rq[2], u_host.rq[3]}, 32'h0)
    // reset pin pulled in mid read
    fork
      u_host.run({3'b101, 45'h0}, 8);
      begin
        repeat (110) @(posedge core_clk);
        @(negedge core_clk);
        `CHK(rwdsOe, 1'b1)
        @(posedge core_clk);
        hwResetN <= 1'b0;
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        `CHK({dqOe, rwdsOe}, 2'b00)
        @(posedge core_clk);
        hwResetN <= 1'b1;
      end
    join
    // after the reset pin: a register-space write is dropped, memory reads on
    u_host.wd[0] = 16'ha55a;
    u_host.wm[0] = 2'b00;
    u_host.run({3'b010, 42'h0, 3'h6}, 1);
    u_host.run({3'b101, 42'h0, 3'h6}, 2);
    `CHK(u_host.rf, 1'b0)
    `CHK(u_host.rq.size(), 4)
    `CHK({u_host.rq[0], u_host.rq[1]}, mem[6])
    `CHK({u_host.rq[2], u_host.rq[3]}, mem[7])
    testDone;
  end
endmodule
bind dpbt_device dpbt_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .hwResetN(hwResetN),
  .chipSelN(chipSelN), .busClk(busClk), .complementClock(complementClock), .dqIn(dqIn),
  .dqOut(dqOut), .dqOe(dqOe), .rwdsIn(rwdsIn), .rwdsOut(rwdsOut), .rwdsOe(rwdsOe));
`default_nettype wire
